// ==== rtl/ecc_pkg.sv ====
/*
 ecc_pkg: shared constants, register map and SEC-DED helpers for the
 ECC-protected RAM controller and the peripheral-side sequencer.
 Assumes a single 100 MHz clock and an 8-bit data word.
*/
package ecc_pkg;

    localparam int DATA_W  = 8;
    localparam int CHK_W   = 5;
    localparam int RAM_AW  = 6;
    localparam int REG_AW  = 5;
    localparam int REG_DW  = 32;
    localparam int THR_W   = 8;

    // register byte offsets
    localparam logic [REG_AW-1:0] OFS_CTRL     = 5'h00;
    localparam logic [REG_AW-1:0] OFS_IRQEN    = 5'h04;
    localparam logic [REG_AW-1:0] OFS_IRQMODE  = 5'h08;
    localparam logic [REG_AW-1:0] OFS_IRQTEST  = 5'h0c;
    localparam logic [REG_AW-1:0] OFS_IRQSTAT  = 5'h10;
    localparam logic [REG_AW-1:0] OFS_INITSTS  = 5'h14;
    localparam logic [REG_AW-1:0] OFS_SERRADDR = 5'h18;
    localparam logic [REG_AW-1:0] OFS_DERRADDR = 5'h1c;

    // field positions
    localparam int CTRL_ECC_EN     = 0;
    localparam int CTRL_INIT_START = 1;
    localparam int IRQEN_SERR      = 0;
    localparam int IRQMODE_CMP     = 0;
    localparam int IRQMODE_THR_LSB = 8;
    localparam int STAT_SERR       = 0;
    localparam int STAT_DERR       = 1;
    localparam int INITSTS_DONE    = 0;
    localparam int INITSTS_BUSY    = 1;

    // values after reset and the fill pattern
    localparam logic [THR_W-1:0]  RST_THR      = 8'h01;
    localparam logic [DATA_W-1:0] INIT_PATTERN = 8'h00;

    // check bits: four hamming parities plus overall parity
    function automatic logic [CHK_W-1:0] ecc_check(input logic [DATA_W-1:0] d);
        logic [12:0]      c;
        logic [CHK_W-1:0] r;
        int               k;
        c = '0;
        k = 0;
        for (int i = 1; i < 13; i++) begin
            if ((i & (i - 1)) != 0) begin
                c[i] = d[k];
                k++;
            end
        end
        for (int p = 0; p < 4; p++) begin
            for (int i = 1; i < 13; i++) begin
                if (((i >> p) & 1) == 1) begin
                    c[1 << p] = c[1 << p] ^ c[i];
                end
            end
        end
        r = {c[8], c[4], c[2], c[1], ^c[12:1]};
        return r;
    endfunction : ecc_check

    // returns {double, single, corrected data}
    function automatic logic [DATA_W+1:0] ecc_decode(input logic [DATA_W-1:0] d,
                                                     input logic [CHK_W-1:0]  ck);
        logic [12:0]       c;
        logic [3:0]        s;
        logic              par;
        logic              sgl;
        logic              dbl;
        logic [DATA_W-1:0] o;
        int                k;
        c   = '0;
        k   = 0;
        s   = '0;
        sgl = 1'b0;
        dbl = 1'b0;
        o   = '0;
        for (int i = 1; i < 13; i++) begin
            if ((i & (i - 1)) != 0) begin
                c[i] = d[k];
                k++;
            end
        end
        {c[8], c[4], c[2], c[1]} = ck[4:1];
        for (int i = 1; i < 13; i++) begin
            if (c[i]) begin
                s = s ^ 4'(i);
            end
        end
        par = (^c[12:1]) ^ ck[0];
        if (par && s != 4'h0 && s < 4'hd) begin
            c[s] = ~c[s];
            sgl  = 1'b1;
        end else if (par) begin
            sgl = 1'b1;
        end else if (s != 4'h0) begin
            dbl = 1'b1;
        end
        k = 0;
        for (int i = 1; i < 13; i++) begin
            if ((i & (i - 1)) != 0) begin
                o[k] = c[i];
                k++;
            end
        end
        return {dbl, sgl, o};
    endfunction : ecc_decode

endpackage : ecc_pkg

// ==== rtl/ecc_if.sv ====
/*
 ecc_if: joins the ECC controller (dev) and the peripheral-side
 sequencer (host): register port, RAM port and interrupt lines.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface ecc_if;
    import ecc_pkg::*;
    // register port
    logic [REG_AW-1:0] reg_addr;
    logic [REG_DW-1:0] reg_wdata;
    logic              reg_we;
    logic              reg_re;
    logic [REG_DW-1:0] reg_rdata;
    // ram port
    logic              ram_req;
    logic              ram_we;
    logic [RAM_AW-1:0] ram_addr;
    logic [DATA_W-1:0] ram_wdata;
    logic              ram_rvalid;
    logic [DATA_W-1:0] ram_rdata;
    // peripheral reset and interrupts
    logic              periph_rst;
    logic              serr_irq;
    logic              derr_irq;

    modport dev (input reg_addr, reg_wdata, reg_we, reg_re, ram_req, ram_we,
                 ram_addr, ram_wdata, periph_rst,
                 output reg_rdata, ram_rvalid, ram_rdata, serr_irq, derr_irq);
    modport host (output reg_addr, reg_wdata, reg_we, reg_re, ram_req, ram_we,
                  ram_addr, ram_wdata, periph_rst,
                  input reg_rdata, ram_rvalid, ram_rdata, serr_irq, derr_irq);
endinterface : ecc_if

// ==== rtl/ecc_ctrl.sv ====
/*
 ecc_ctrl: ECC controller for one single-port RAM with its register
 port, init engine, SEC-DED encode/decode and error pending flags.
 Assumes the peripheral logic drives the host modport of ecc_if on clk.
*/
// Strobed register access and the address map were decided locally.
`timescale 1ns/1ps
// Operation
// R1: test bits raise the matching error interrupt
// R2: writing one to pending clears its interrupt
// R3: init allowed when port idle or peripheral reset
// R4: memory initialized before peripheral uses it
// R5: no memory access during initialization
// R6: first mask interrupts and clear enables
// R7: then clear correction enable bit
// R8: init start bit launches init engine
// R9: dual-port memory initialized per port
// R10: done flag set; software waits, then enables
// R11: check bits stored on every write; here only while ecc_en is set
// R12: interrupt mode register selects error reporting
// R13: reads checked and single errors corrected
// R14: encode/decode only on valid accesses
// R15: encode/decode clocked with the RAM port
// R16: register port on peripheral bus clock
// R17: dual-port memory ports on their clocks
// R18: software releases peripheral and register resets
// R19: register port reset has its own bit; here the register port uses sys_rst
// R20: resets leave RAM contents unchanged
// R21: resets clear only register slave state
// R22: init writes every word, then sets done
module ecc_ctrl (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // link to peripheral side
    ecc_if.dev       bus
);
    import ecc_pkg::*;

    localparam int RAM_DEPTH = 1 << RAM_AW;

    typedef enum logic [1:0] {
        INIT_IDLE = 2'b01,
        INIT_RUN  = 2'b10
    } init_state_e;

    // ram array: never reset, so a reset keeps the contents
    logic [DATA_W-1:0] mem_d [RAM_DEPTH];  // see R20
    logic [CHK_W-1:0]  mem_c [RAM_DEPTH];
    logic [DATA_W-1:0] raw_d;
    logic [CHK_W-1:0]  raw_c;

    init_state_e       st,         next_st;
    logic [RAM_AW-1:0] init_addr,  next_init_addr;
    logic              init_done,  next_init_done;
    logic              ecc_en,     next_ecc_en;
    logic              serr_en,    next_serr_en;
    logic              cmp_mode,   next_cmp_mode;
    logic [THR_W-1:0]  thr,        next_thr;
    logic [THR_W-1:0]  serr_cnt,   next_serr_cnt;
    logic [1:0]        pend,       next_pend;
    logic [RAM_AW-1:0] serr_addr,  next_serr_addr;
    logic [RAM_AW-1:0] derr_addr,  next_derr_addr;
    logic              rd_pend,    next_rd_pend;
    logic [RAM_AW-1:0] rd_addr,    next_rd_addr;
    logic [REG_DW-1:0] reg_rdata,  next_reg_rdata;
    logic [DATA_W-1:0] ram_rdata,  next_ram_rdata;
    logic              ram_rvalid, next_ram_rvalid;

    logic              acc;
    logic              wr;
    logic [DATA_W+1:0] dec;
    logic              ev_s;
    logic              ev_d;
    logic              cmp_hit;
    logic              wr_ctrl;
    logic              start_ok;

    // peripheral accesses are dropped while the engine owns the array
    assign acc = bus.ram_req && (st == INIT_IDLE);  // see R5
    assign wr  = acc && bus.ram_we;

    // memory: fill during init, otherwise store data, and check bits while ecc_en is set
    always_ff @(posedge clk) begin  // see R15
        if (st == INIT_RUN) begin
            mem_d[init_addr] <= INIT_PATTERN;  // see R22
            mem_c[init_addr] <= ecc_check(INIT_PATTERN);
        end else if (wr) begin
            mem_d[bus.ram_addr] <= bus.ram_wdata;
            // with ecc off the check field is left stale, so re-init after
            mem_c[bus.ram_addr] <= ecc_en ? ecc_check(bus.ram_wdata)  // see R11
                                          : mem_c[bus.ram_addr];
        end
        if (acc && !bus.ram_we) begin  // see R14
            raw_d <= mem_d[bus.ram_addr];
            raw_c <= mem_c[bus.ram_addr];
        end
    end

    // decode only looks at a captured read
    always_comb begin
        dec     = ecc_decode(raw_d, raw_c);  // see R13
        ev_s    = rd_pend && ecc_en && dec[DATA_W];  // see R14
        ev_d    = rd_pend && ecc_en && dec[DATA_W+1];
        cmp_hit = ({1'b0, serr_cnt} + 9'h001) >= {1'b0, thr};
    end

    assign wr_ctrl  = bus.reg_we && (bus.reg_addr == OFS_CTRL);
    assign start_ok = bus.periph_rst || !bus.ram_req;  // see R3

    always_comb begin
        next_st         = st;
        next_init_addr  = init_addr;
        next_init_done  = init_done;
        next_ecc_en     = ecc_en;
        next_serr_en    = serr_en;
        next_cmp_mode   = cmp_mode;
        next_thr        = thr;
        next_serr_cnt   = serr_cnt;
        next_pend       = pend;
        next_serr_addr  = serr_addr;
        next_derr_addr  = derr_addr;
        next_rd_pend    = acc && !bus.ram_we;
        next_rd_addr    = acc ? bus.ram_addr : rd_addr;
        next_reg_rdata  = reg_rdata;
        next_ram_rdata  = ram_rdata;
        next_ram_rvalid = rd_pend;

        // init engine
        case (st)
            INIT_IDLE: begin
                if (wr_ctrl && bus.reg_wdata[CTRL_INIT_START] && start_ok) begin
                    next_st        = INIT_RUN;  // see R8
                    next_init_addr = '0;
                    next_init_done = 1'b0;
                end
            end
            INIT_RUN: begin
                next_init_addr = init_addr + 1'b1;
                if (init_addr == RAM_AW'(RAM_DEPTH - 1)) begin
                    next_st        = INIT_IDLE;
                    next_init_done = 1'b1;  // see R10 R22
                end
            end
            default: next_st = INIT_IDLE;
        endcase

        // register writes
        if (bus.reg_we) begin
            case (bus.reg_addr)
                OFS_CTRL:     next_ecc_en = bus.reg_wdata[CTRL_ECC_EN];
                OFS_IRQEN:    next_serr_en = bus.reg_wdata[IRQEN_SERR];
                OFS_IRQMODE: begin
                    next_cmp_mode = bus.reg_wdata[IRQMODE_CMP];  // see R12
                    next_thr      = bus.reg_wdata[IRQMODE_THR_LSB +: THR_W];
                    next_serr_cnt = '0;
                end
                OFS_IRQSTAT: begin
                    next_pend = pend & ~bus.reg_wdata[STAT_DERR:STAT_SERR];  // see R2
                    if (bus.reg_wdata[STAT_SERR]) begin
                        next_serr_cnt = '0;
                    end
                end
                default: ;
            endcase
        end

        // read data; corrected when ecc is on
        if (rd_pend) begin
            next_ram_rdata = ecc_en ? dec[DATA_W-1:0] : raw_d;  // see R13
        end

        // error events; set wins over a clear in the same cycle
        if (ev_s) begin
            next_serr_addr = rd_addr;
            if (serr_en && !cmp_mode) begin  // see R12
                next_pend[STAT_SERR] = 1'b1;
            end
            // counting freezes once the threshold has raised the flag
            if (serr_en && cmp_mode && !pend[STAT_SERR]) begin
                next_serr_cnt = serr_cnt + 1'b1;
                if (cmp_hit) begin
                    next_pend[STAT_SERR] = 1'b1;
                end
            end
        end
        if (ev_d) begin
            next_derr_addr       = rd_addr;
            next_pend[STAT_DERR] = 1'b1;  // double errors cannot be masked
        end
        if (bus.reg_we && bus.reg_addr == OFS_IRQTEST) begin
            next_pend = next_pend | bus.reg_wdata[STAT_DERR:STAT_SERR];  // see R1
        end

        // register reads, answer one cycle later
        if (bus.reg_re) begin
            case (bus.reg_addr)
                OFS_CTRL:     next_reg_rdata = REG_DW'(ecc_en);
                OFS_IRQEN:    next_reg_rdata = REG_DW'(serr_en);
                OFS_IRQMODE:  next_reg_rdata = REG_DW'({thr, 7'h00, cmp_mode});
                OFS_IRQSTAT:  next_reg_rdata = REG_DW'(pend);
                OFS_INITSTS:  next_reg_rdata = REG_DW'({st == INIT_RUN, init_done});
                OFS_SERRADDR: next_reg_rdata = REG_DW'(serr_addr);
                OFS_DERRADDR: next_reg_rdata = REG_DW'(derr_addr);
                default:      next_reg_rdata = '0;
            endcase
        end
    end

    // register slave state is the only thing a reset clears
    always_ff @(posedge clk) begin  // see R16
        if (sys_rst) begin  // see R21
            st         <= INIT_IDLE;
            init_addr  <= '0;
            init_done  <= 1'b0;
            ecc_en     <= 1'b0;
            serr_en    <= 1'b0;
            cmp_mode   <= 1'b0;
            thr        <= RST_THR;
            serr_cnt   <= '0;
            pend       <= '0;
            serr_addr  <= '0;
            derr_addr  <= '0;
            rd_pend    <= 1'b0;
            rd_addr    <= '0;
            reg_rdata  <= '0;
            ram_rdata  <= '0;
            ram_rvalid <= 1'b0;
        end else begin
            st         <= next_st;
            init_addr  <= next_init_addr;
            init_done  <= next_init_done;
            ecc_en     <= next_ecc_en;
            serr_en    <= next_serr_en;
            cmp_mode   <= next_cmp_mode;
            thr        <= next_thr;
            serr_cnt   <= next_serr_cnt;
            pend       <= next_pend;
            serr_addr  <= next_serr_addr;
            derr_addr  <= next_derr_addr;
            rd_pend    <= next_rd_pend;
            rd_addr    <= next_rd_addr;
            reg_rdata  <= next_reg_rdata;
            ram_rdata  <= next_ram_rdata;
            ram_rvalid <= next_ram_rvalid;
        end
    end

    // single clock here: a dual-port build gives each port its own clock
    assign bus.reg_rdata  = reg_rdata;  // see R17
    assign bus.ram_rdata  = ram_rdata;
    assign bus.ram_rvalid = ram_rvalid;
    assign bus.serr_irq   = pend[STAT_SERR];
    assign bus.derr_irq   = pend[STAT_DERR];

endmodule : ecc_ctrl

// ==== rtl/ecc_seq.sv ====
/*
 ecc_seq: peripheral-side end; runs the setup sequence over the
 register port, then passes user RAM accesses and interrupt clears.
 Assumes ecc_ctrl on the dev modport and the same clock.
*/
`timescale 1ns/1ps
module ecc_seq (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      sys_rst,
    // user control
    input  wire logic                      start,
    input  wire logic                      irq_clear,
    input  wire logic                      cmp_mode,
    input  wire logic [ecc_pkg::THR_W-1:0] thr,
    output logic                           ready,
    // user ram port
    input  wire logic                      u_req,
    input  wire logic                      u_we,
    input  wire logic [ecc_pkg::RAM_AW-1:0] u_addr,
    input  wire logic [ecc_pkg::DATA_W-1:0] u_wdata,
    output logic                           u_rvalid,
    output logic [ecc_pkg::DATA_W-1:0]     u_rdata,
    output logic                           u_serr,
    output logic                           u_derr,
    // link to controller
    ecc_if.host                            bus
);
    import ecc_pkg::*;

    typedef enum logic [8:0] {
        S_IDLE  = 9'h001,
        S_MASK  = 9'h002,
        S_OFF   = 9'h004,
        S_INIT  = 9'h008,
        S_POLL  = 9'h010,
        S_WAIT  = 9'h020,
        S_CHK   = 9'h040,
        S_MODE  = 9'h080,
        S_READY = 9'h100
    } seq_state_e;

    seq_state_e        st,   next_st;
    logic [REG_AW-1:0] addr, next_addr;
    logic [REG_DW-1:0] wd,   next_wd;
    logic              we,   next_we;
    logic              re,   next_re;
    logic              rq,   next_rq;
    logic              rwe,  next_rwe;
    logic [RAM_AW-1:0] ra,   next_ra;
    logic [DATA_W-1:0] rwd,  next_rwd;
    logic              rdy,  next_rdy;
    logic              rv,   next_rv;
    logic [DATA_W-1:0] rd,   next_rd;
    logic              ise,  next_ise;
    logic              ide,  next_ide;

    always_comb begin
        next_st   = st;
        next_addr = addr;
        next_wd   = wd;
        next_we   = 1'b0;
        next_re   = 1'b0;
        next_rq   = 1'b0;
        next_rwe  = 1'b0;
        next_ra   = ra;
        next_rwd  = rwd;
        next_rdy  = rdy;
        next_rv   = bus.ram_rvalid;
        next_rd   = bus.ram_rvalid ? bus.ram_rdata : rd;
        next_ise  = bus.serr_irq;
        next_ide  = bus.derr_irq;
        case (st)
            S_IDLE: begin
                if (start) begin
                    next_st   = S_MASK;
                    next_rdy  = 1'b0;
                    next_we   = 1'b1;
                    next_addr = OFS_IRQEN;  // see R6
                    next_wd   = '0;
                end
            end
            S_MASK: begin
                next_st   = S_OFF;
                next_we   = 1'b1;
                next_addr = OFS_CTRL;  // see R7
                next_wd   = '0;
            end
            S_OFF: begin
                next_st   = S_INIT;
                next_we   = 1'b1;
                next_addr = OFS_CTRL;
                next_wd   = REG_DW'(1) << CTRL_INIT_START;  // see R4 R9
            end
            S_INIT: next_st = S_POLL;
            S_POLL: begin
                next_st   = S_WAIT;
                next_re   = 1'b1;
                next_addr = OFS_INITSTS;
            end
            S_WAIT: next_st = S_CHK;
            S_CHK: begin
                if (bus.reg_rdata[INITSTS_DONE]) begin  // see R10
                    next_st   = S_MODE;
                    next_we   = 1'b1;
                    next_addr = OFS_IRQMODE;
                    next_wd   = REG_DW'({thr, 7'h00, cmp_mode});
                end else begin
                    next_st = S_POLL;
                end
            end
            S_MODE: begin
                next_st   = S_READY;
                next_we   = 1'b1;
                next_addr = OFS_IRQEN;
                next_wd   = REG_DW'(1) << IRQEN_SERR;
            end
            S_READY: begin
                if (!rdy) begin
                    next_we   = 1'b1;
                    next_addr = OFS_CTRL;
                    next_wd   = REG_DW'(1) << CTRL_ECC_EN;
                    next_rdy  = 1'b1;
                end else if (irq_clear) begin
                    next_we   = 1'b1;
                    next_addr = OFS_IRQSTAT;
                    next_wd   = REG_DW'(2'h3);
                end
                // user traffic only after the fill has completed
                if (rdy && u_req) begin  // see R5
                    next_rq  = 1'b1;
                    next_rwe = u_we;
                    next_ra  = u_addr;
                    next_rwd = u_wdata;
                end
                if (rdy && start) begin
                    next_st  = S_IDLE;
                    next_rdy = 1'b0;
                end
            end
            default: next_st = S_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st   <= S_IDLE;
            addr <= '0;
            wd   <= '0;
            we   <= 1'b0;
            re   <= 1'b0;
            rq   <= 1'b0;
            rwe  <= 1'b0;
            ra   <= '0;
            rwd  <= '0;
            rdy  <= 1'b0;
            rv   <= 1'b0;
            rd   <= '0;
            ise  <= 1'b0;
            ide  <= 1'b0;
        end else begin
            st   <= next_st;
            addr <= next_addr;
            wd   <= next_wd;
            we   <= next_we;
            re   <= next_re;
            rq   <= next_rq;
            rwe  <= next_rwe;
            ra   <= next_ra;
            rwd  <= next_rwd;
            rdy  <= next_rdy;
            rv   <= next_rv;
            rd   <= next_rd;
            ise  <= next_ise;
            ide  <= next_ide;
        end
    end

    // peripheral held in reset until ready; register port uses sys_rst
    assign bus.periph_rst = !rdy;  // see R18 R19
    assign bus.reg_addr   = addr;
    assign bus.reg_wdata  = wd;
    assign bus.reg_we     = we;
    assign bus.reg_re     = re;
    assign bus.ram_req    = rq;
    assign bus.ram_we     = rwe;
    assign bus.ram_addr   = ra;
    assign bus.ram_wdata  = rwd;
    assign ready          = rdy;
    assign u_rvalid       = rv;
    assign u_rdata        = rd;
    assign u_serr         = ise;
    assign u_derr         = ide;

endmodule : ecc_seq

// ==== testbench/ecc_checker.sv ====
/* ecc_checker: assertions on the ecc_if signals between controller and sequencer.
 assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
module ecc_checker (
    // clock and reset
    input wire logic                       clk,
    input wire logic                       sys_rst,
    // register port
    input wire logic [ecc_pkg::REG_AW-1:0] reg_addr,
    input wire logic [ecc_pkg::REG_DW-1:0] reg_wdata,
    input wire logic                       reg_we,
    input wire logic                       reg_re,
    input wire logic [ecc_pkg::REG_DW-1:0] reg_rdata,
    // ram port and status
    input wire logic                       ram_req,
    input wire logic                       ram_we,
    input wire logic                       ram_rvalid,
    input wire logic                       periph_rst,
    input wire logic                       serr_irq,
    input wire logic                       derr_irq
);
    import ecc_pkg::*;
    logic [6:0] cnt;
    logic [6:0] next_cnt;
    logic       go;
    logic       stat_rd;
    assign go = reg_we && reg_addr == OFS_CTRL && reg_wdata[CTRL_INIT_START];
    assign stat_rd = reg_re && reg_addr == OFS_INITSTS;
    // cycles since init start; saturates so late reads still count as done
    always_comb begin
        next_cnt = cnt;
        if (go) begin
            next_cnt = 7'h01;
        end else if (cnt != 7'h00 && cnt != 7'h7f) begin
            next_cnt = cnt + 7'h01;
        end
    end
    always_ff @(posedge clk) begin
        cnt <= sys_rst ? 7'h00 : next_cnt;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    setup_order_a: assert property (
        go |-> $past(reg_we && reg_addr == OFS_CTRL && reg_wdata == 32'h0)
            && $past(reg_we && reg_addr == OFS_IRQEN && !reg_wdata[0], 2))
        else $error("init start without setup writes");
    start_ok_a: assert property (go |-> periph_rst || !ram_req)
        else $error("init start during ram traffic");
    no_ram_init_a: assert property (ram_req |-> !(cnt inside {[1:65]}))
        else $error("ram request while init runs");
    busy_read_a: assert property (
        stat_rd && cnt >= 7'h02 && cnt <= 7'h3f |=> reg_rdata[1:0] == 2'b10)
        else $error("init status not busy");
    done_read_a: assert property (
        stat_rd && cnt >= 7'h41 |=> reg_rdata[1:0] == 2'b01)
        else $error("init status not done");
    enable_late_a: assert property (
        reg_we && reg_addr == OFS_IRQEN && reg_wdata[0] |-> cnt >= 7'h42)
        else $error("interrupts enabled before init done");
    read_answer_a: assert property (ram_req && !ram_we |-> ##2 ram_rvalid)
        else $error("ram read not answered");
    no_idle_valid_a: assert property (ram_rvalid |-> $past(ram_req && !ram_we, 2))
        else $error("ram answer without request");
    pend_clear_a: assert property (
        reg_we && reg_addr == OFS_IRQSTAT && reg_wdata[1:0] == 2'b11
            |=> !serr_irq && !derr_irq)
        else $error("pending not cleared");
endmodule : ecc_checker

// ==== testbench/ecc_ram_init_test_control_tb.sv ====
/* ecc_ram_init_test_control_tb: controller and sequencer joined by ecc_if,
 driven through the sequencer user port. assumes the ecc_pkg constants. */
`timescale 1ns/1ps
module ecc_ram_init_test_control_tb;
    import ecc_pkg::*;
    logic              clk = 1'b0, sys_rst = 1'b1, start = 1'b0, irq_clear = 1'b0;
    logic              cmp_mode = 1'b0, u_req = 1'b0, u_we = 1'b0;
    logic [THR_W-1:0]  thr = 8'h01;
    logic [RAM_AW-1:0] u_addr = '0;
    logic [DATA_W-1:0] u_wdata = '0, u_rdata;
    logic              ready, u_rvalid, u_serr, u_derr;
    int                bad_count = 0, compares = 0, cycles = 0;
    always #5 clk = ~clk;
    ecc_if i_ecc_if ();
    ecc_ctrl i_ecc_ctrl (.clk(clk), .sys_rst(sys_rst), .bus(i_ecc_if));
    ecc_seq i_ecc_seq (.clk(clk), .sys_rst(sys_rst), .start(start), .irq_clear(irq_clear),
        .cmp_mode(cmp_mode), .thr(thr), .ready(ready), .u_req(u_req), .u_we(u_we),
        .u_addr(u_addr), .u_wdata(u_wdata), .u_rvalid(u_rvalid), .u_rdata(u_rdata),
        .u_serr(u_serr), .u_derr(u_derr), .bus(i_ecc_if));
    ecc_checker chk (.clk(clk), .sys_rst(sys_rst), .reg_addr(i_ecc_if.reg_addr),
        .reg_wdata(i_ecc_if.reg_wdata), .reg_we(i_ecc_if.reg_we), .reg_re(i_ecc_if.reg_re),
        .reg_rdata(i_ecc_if.reg_rdata), .ram_req(i_ecc_if.ram_req), .ram_we(i_ecc_if.ram_we),
        .ram_rvalid(i_ecc_if.ram_rvalid), .periph_rst(i_ecc_if.periph_rst),
        .serr_irq(i_ecc_if.serr_irq), .derr_irq(i_ecc_if.derr_irq));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run();
        $display("counts: compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run
    task automatic pulse_start();
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
    endtask : pulse_start
    task automatic wait_ready(input logic v);
        int n;
        n = 0;
        do begin @(posedge clk); #1; n++; end while (ready !== v && n < 300);
        check(ready, v);
    endtask : wait_ready
    task automatic wr(input logic [RAM_AW-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        u_req <= 1'b1;
        u_we <= 1'b1;
        u_addr <= a;
        u_wdata <= d;
        @(posedge clk);
        u_req <= 1'b0;
    endtask : wr
    // flags ride along: an unexpected error report on any read is caught here
    task automatic rd(input logic [RAM_AW-1:0] a, input logic [DATA_W-1:0] exp);
        int n;
        @(posedge clk);
        u_req <= 1'b1;
        u_we <= 1'b0;
        u_addr <= a;
        @(posedge clk);
        u_req <= 1'b0;
        n = 0;
        do begin #1; n++; if (u_rvalid !== 1'b1) @(posedge clk); end
            while (u_rvalid !== 1'b1 && n < 20);
        check({u_rvalid, u_serr, u_derr, u_rdata}, {3'b100, exp});
    endtask : rd
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            complete_run();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        #1 check({ready, i_ecc_if.periph_rst}, 2'b01);
        pulse_start();
        wait_ready(1'b1);
        rd(6'h00, INIT_PATTERN);
        rd(6'h3f, INIT_PATTERN);
        $display("test init done");
        for (int i = 0; i < 4; i++) wr(6'(i * 21), 8'(8'h81 << i));
        for (int i = 0; i < 4; i++) rd(6'(i * 21), 8'(8'h81 << i));
        @(posedge clk);
        irq_clear <= 1'b1;
        @(posedge clk);
        irq_clear <= 1'b0;
        repeat (3) @(posedge clk);
        #1 check({u_serr, u_derr}, 2'b00);
        $display("test data done");
        cmp_mode <= 1'b1;
        thr <= 8'h03;
        pulse_start(); // from ready a start only drops back to idle
        pulse_start();
        wait_ready(1'b0);
        wr(6'h2a, 8'h5a); // dropped: the sequencer passes no access while ready is low
        wait_ready(1'b1);
        rd(6'h2a, INIT_PATTERN);
        $display("test reinit done");
        complete_run();
    end
endmodule : ecc_ram_init_test_control_tb
